// *** dv/fbs_od_master.sv ***
`timescale 1ns/1ps
module fbs_od_master (
   // clock
   input  logic        clock,
   // request side
   output logic        odRequest,
   output logic        odWrite,
   output logic [15:0] odIndex,
   output logic [7:0]  odSubIndex,
   output logic [31:0] odWriteData,
   // answer side
   input  logic        odAck,
   input  logic        odAbort,
   input  logic [31:0] odReadData
);
   // idle bus at time zero
   initial begin
      odRequest   = 1'b0;
      odWrite     = 1'b0;
      odIndex     = 16'h0000;
      odSubIndex  = 8'h00;
      odWriteData = 32'h00000000;
   end
   // one access: request for one taking edge, then collect the answer
   task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                         input logic [31:0] d, output logic [31:0] rd, output logic ab, output logic ok);
      int n;
      @(posedge clock);
      #1;
      {odRequest, odWrite, odIndex, odSubIndex, odWriteData} = {1'b1, wr, idx, sub, d};
      @(posedge clock);
      #1;
      // released fields show the inverse so stale values never look valid
      {odRequest, odWrite, odIndex, odSubIndex, odWriteData} = {1'b0, ~wr, ~idx, ~sub, ~d};
      for (n = 0; n < 4 && odAck !== 1'b1; n++) begin
         @(posedge clock);
         #1;
      end
      ok = (n == 0) && (odAck === 1'b1);
      ab = odAbort;
      rd = odReadData;
   endtask : access
endmodule : fbs_od_master

// *** dv/fbs_properties.sv ***
`timescale 1ns/1ps
module fbs_properties #(
   parameter int          NUM_SENSORS = 2,
   parameter logic [15:0] MAP_FIRST   = 16'h3380,
   parameter logic [15:0] MAP_SECOND  = 16'h33A0
) (
   // clock and reset
   input logic               clock,
   input logic               reset_n,
   // object access
   input logic               odRequest,
   input logic               odWrite,
   input logic [15:0]        odIndex,
   input logic [7:0]         odSubIndex,
   input logic               odAck,
   input logic               odAbort,
   input logic [31:0]        odReadData,
   // drive state and results
   input logic               operationEnabled,
   input logic [31:0]        driveSubmodeSetting,
   input logic [7:0]         positionSource,
   input logic [7:0]         velocitySource,
   input logic [7:0]         commutationSource,
   input logic               closedLoopActive,
   input logic               feedForwardEnabled,
   input logic signed [31:0] accelFeedForward
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // reads of the selection count and of the mapping entries
   wire rdCount = odRequest && !odWrite && odIndex == fbs_pkg::SELECT_INDEX && odSubIndex == 8'h00;
   wire rdMap   = odRequest && !odWrite && odIndex == fbs_pkg::MAP_INDEX && odSubIndex inside {8'h01, 8'h02};
   a_loop_follow: assert property (!operationEnabled |=> closedLoopActive == $past(driveSubmodeSetting[0]))
      else $error("loop closure did not follow the submode bit");
   a_loop_frozen: assert property (operationEnabled && $past(operationEnabled) |=> $stable(closedLoopActive))
      else $error("loop closure changed while operation enabled");
   a_src_frozen: assert property (operationEnabled [*3] |=> $stable(positionSource) && $stable(velocitySource)
      && $stable(commutationSource)) else $error("sources changed while operation enabled");
   a_com_open: assert property (!closedLoopActive |=> commutationSource == fbs_pkg::SENSORLESS)
      else $error("commutation source used in open loop");
   a_ro_abort: assert property (odRequest && odWrite && (odIndex == fbs_pkg::MAP_INDEX || odSubIndex == 8'h00)
      |=> odAck && odAbort) else $error("write to read-only entry not refused");
   a_count_read: assert property (rdCount |=> odAck && !odAbort && odReadData == 32'(NUM_SENSORS))
      else $error("selection count wrong");
   a_map_read: assert property (rdMap |=> odAck && !odAbort && odReadData ==
      {16'h0000, ($past(odSubIndex) == 8'h01) ? MAP_FIRST : MAP_SECOND}) else $error("mapping entry wrong");
   a_ff_zero: assert property (!feedForwardEnabled |=> accelFeedForward == 32'sh0)
      else $error("feed-forward active while disabled");
endmodule : fbs_properties

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
   // one selection case: masks and loop closure in, sources out
   typedef struct packed {
      logic [7:0] maskFirst;
      logic [7:0] maskSecond;
      logic       closed;
      logic [7:0] pos;
      logic [7:0] vel;
      logic [7:0] com;
   } fbs_row_type;
   logic clock, reset_n, odRequest, odWrite, odAck, odAbort, operationEnabled;
   logic closedLoopActive, feedForwardEnabled, ab, ok;
   logic [15:0] odIndex;
   logic [7:0] odSubIndex, positionSource, velocitySource, commutationSource;
   logic [31:0] odWriteData, odReadData, driveSubmodeSetting, rd;
   logic signed [31:0] accelDemand, accelFeedForward;
   fbs_row_type rows [8];
   int n_fail;
   int compares;
   fbs_feedback_select fbs_feedback_select_i (.clock(clock), .reset_n(reset_n), .odRequest(odRequest),
      .odWrite(odWrite), .odIndex(odIndex), .odSubIndex(odSubIndex), .odWriteData(odWriteData), .odAck(odAck),
      .odAbort(odAbort), .odReadData(odReadData), .operationEnabled(operationEnabled),
      .driveSubmodeSetting(driveSubmodeSetting), .accelDemand(accelDemand), .positionSource(positionSource),
      .velocitySource(velocitySource), .commutationSource(commutationSource), .closedLoopActive(closedLoopActive),
      .feedForwardEnabled(feedForwardEnabled), .accelFeedForward(accelFeedForward));
   fbs_od_master fbs_od_master_i (.clock(clock), .odRequest(odRequest), .odWrite(odWrite), .odIndex(odIndex),
      .odSubIndex(odSubIndex), .odWriteData(odWriteData), .odAck(odAck), .odAbort(odAbort), .odReadData(odReadData));
   // compare one value and count it
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // access with answer checks; data checked on reads only
   task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic a);
      fbs_od_master_i.access(w, i, s, d, rd, ab, ok);
      check("answer", 32'h1, 32'(ok));
      check("refusal", 32'(a), 32'(ab));
      if (!w) begin
         check("read data", d, rd);
      end
   endtask : acc
   // wait edges, then step off the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   // compare the three chosen sources
   task automatic src(input logic [7:0] p, input logic [7:0] v, input logic [7:0] c);
      check("position source", 32'(p), 32'(positionSource));
      check("velocity source", 32'(v), 32'(velocitySource));
      check("commutation source", 32'(c), 32'(commutationSource));
   endtask : src
   // wait bounded for the feed-forward value, then compare
   task automatic ffw(input logic signed [31:0] e);
      for (int n = 0; n < 300 && accelFeedForward !== e; n++) cyc(1);
      check("feed-forward", e, accelFeedForward);
      check("feed-forward on", 32'h1, 32'(feedForwardEnabled));
   endtask : ffw
   // print counts and verdict, then stop
   task automatic conclude;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude
   // free-running clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // watchdog
   initial begin
      #(40 * 5000);
      n_fail++;
      conclude();
   end
   initial begin
      n_fail = 0;
      compares = 0;
      {reset_n, operationEnabled, driveSubmodeSetting, accelDemand} = {2'b00, 32'h00000001, 32'sh0};
      rows = '{'{8'h00, 8'h07, 1'b1, 8'h02, 8'h02, 8'h02}, '{8'h00, 8'h07, 1'b0, 8'h02, 8'h02, 8'h01},
               '{8'h07, 8'h00, 1'b1, 8'h01, 8'h01, 8'h01}, '{8'h00, 8'h01, 1'b1, 8'h02, 8'h01, 8'h01},
               '{8'h00, 8'h02, 1'b1, 8'h01, 8'h02, 8'h01}, '{8'h00, 8'h04, 1'b1, 8'h01, 8'h01, 8'h02},
               '{8'h00, 8'h04, 1'b0, 8'h01, 8'h01, 8'h01}, '{8'h07, 8'hF8, 1'b1, 8'h01, 8'h01, 8'h01}};
      cyc(6);
      reset_n = 1'b1;
      foreach (rows[i]) begin
         driveSubmodeSetting = {31'h0, rows[i].closed};
         acc(1'b1, fbs_pkg::SELECT_INDEX, fbs_pkg::SUB_FIRST, 32'(rows[i].maskFirst), 1'b0);
         acc(1'b1, fbs_pkg::SELECT_INDEX, fbs_pkg::SUB_SECOND, 32'(rows[i].maskSecond), 1'b0);
         cyc(3);
         src(rows[i].pos, rows[i].vel, rows[i].com);
      end
      $display("test selection rows done");
      acc(1'b1, fbs_pkg::SELECT_INDEX, fbs_pkg::SUB_SECOND, 32'h7, 1'b0);
      cyc(3);
      operationEnabled = 1'b1;
      cyc(2);
      acc(1'b1, fbs_pkg::SELECT_INDEX, fbs_pkg::SUB_SECOND, 32'h0, 1'b0);
      driveSubmodeSetting = 32'h0;
      cyc(4);
      src(8'h02, 8'h02, 8'h02);
      check("loop held", 32'h1, 32'(closedLoopActive));
      acc(1'b0, fbs_pkg::SELECT_INDEX, fbs_pkg::SUB_SECOND, 32'h0, 1'b0);
      operationEnabled = 1'b0;
      cyc(3);
      src(8'h02, 8'h02, 8'h01);
      operationEnabled = 1'b1;
      cyc(3);
      src(8'h01, 8'h01, 8'h01);
      operationEnabled = 1'b0;
      $display("test buffering done");
      acc(1'b1, fbs_pkg::MAP_INDEX, fbs_pkg::SUB_FIRST, 32'h0, 1'b1);
      acc(1'b1, fbs_pkg::SELECT_INDEX, fbs_pkg::SUB_COUNT, 32'h5, 1'b1);
      acc(1'b0, 16'h1234, 8'h00, 32'h0, 1'b1);
      acc(1'b0, fbs_pkg::SELECT_INDEX, 8'h03, 32'h0, 1'b1);
      $display("test refusals done");
      accelDemand = 32'sd100;
      acc(1'b1, fbs_pkg::INERTIA_INDEX, fbs_pkg::SUB_FIRST, 32'd1000, 1'b0);
      acc(1'b1, fbs_pkg::INERTIA_INDEX, fbs_pkg::SUB_SECOND, 32'd500, 1'b0);
      ffw(32'sd200);
      accelDemand = -32'sd100;
      ffw(-32'sd200);
      acc(1'b1, fbs_pkg::INERTIA_INDEX, fbs_pkg::SUB_FIRST, 32'h0, 1'b0);
      cyc(2);
      check("feed-forward off", 32'h0, {31'h0, feedForwardEnabled} | accelFeedForward);
      $display("test feed-forward done");
      reset_n = 1'b0;
      cyc(2);
      src(8'h01, 8'h01, 8'h01);
      reset_n = 1'b1;
      acc(1'b0, fbs_pkg::SELECT_INDEX, fbs_pkg::SUB_COUNT, 32'h02, 1'b0);
      acc(1'b0, fbs_pkg::SELECT_INDEX, fbs_pkg::SUB_FIRST, 32'h00, 1'b0);
      acc(1'b0, fbs_pkg::SELECT_INDEX, fbs_pkg::SUB_SECOND, 32'h07, 1'b0);
      acc(1'b0, fbs_pkg::MAP_INDEX, fbs_pkg::SUB_COUNT, 32'h02, 1'b0);
      acc(1'b0, fbs_pkg::MAP_INDEX, fbs_pkg::SUB_FIRST, 32'h3380, 1'b0);
      acc(1'b0, fbs_pkg::MAP_INDEX, fbs_pkg::SUB_SECOND, 32'h33A0, 1'b0);
      acc(1'b0, fbs_pkg::INERTIA_INDEX, fbs_pkg::SUB_COUNT, 32'h02, 1'b0);
      acc(1'b0, fbs_pkg::INERTIA_INDEX, fbs_pkg::SUB_FIRST, 32'h0, 1'b0);
      acc(1'b0, fbs_pkg::INERTIA_INDEX, fbs_pkg::SUB_SECOND, 32'h0, 1'b0);
      $display("test reset values done");
      conclude();
   end
endmodule : tb
bind fbs_feedback_select fbs_properties #(.NUM_SENSORS(NUM_SENSORS), .MAP_FIRST(MAP_FIRST), .MAP_SECOND(MAP_SECOND))
   fbs_properties_i (.clock(clock), .reset_n(reset_n), .odRequest(odRequest), .odWrite(odWrite),
   .odIndex(odIndex), .odSubIndex(odSubIndex), .odAck(odAck), .odAbort(odAbort), .odReadData(odReadData),
   .operationEnabled(operationEnabled), .driveSubmodeSetting(driveSubmodeSetting),
   .positionSource(positionSource), .velocitySource(velocitySource), .commutationSource(commutationSource),
   .closedLoopActive(closedLoopActive), .feedForwardEnabled(feedForwardEnabled),
   .accelFeedForward(accelFeedForward));

// *** src/fbs_feedback_select.sv ***
`timescale 1ns/1ps
// How it works
// - selection mask writes during operation enabled wait for re-entry
// - selection count reports existing sensor number
// - mask bit 0 marks position candidate
// - mask bit 1 marks velocity candidate
// - mask bit 2 marks closed-loop commutation candidate
// - entry one is always the sensorless feedback
// - search descends from last sensor to sensor two
// - lowest matching sensor wins, it is written last
// - open loop ignores commutation bit
// - open loop still picks position, velocity
// - mapping entries return configuration indices, read-only
// - zero inertia factor disables feed-forward, reset zero
// - feed-forward acts while decelerating too
// - submode bit 0 selects open or closed
module fbs_feedback_select #(
   // number of existing feedback sensors, sensorless included
   parameter int          NUM_SENSORS = 2,
   // configuration object index of sensors one and two
   parameter logic [15:0] MAP_FIRST   = fbs_pkg::MAP_FIRST_RST,
   parameter logic [15:0] MAP_SECOND  = fbs_pkg::MAP_SECOND_RST
) (
   // clock and reset
   input  wire logic               clock,
   input  wire logic               reset_n,
   // object dictionary access
   input  wire logic               odRequest,
   input  wire logic               odWrite,
   input  wire logic [15:0]        odIndex,
   input  wire logic [7:0]         odSubIndex,
   input  wire logic [31:0]        odWriteData,
   output logic                    odAck,
   output logic                    odAbort,
   output logic [31:0]             odReadData,
   // drive state
   input  wire logic               operationEnabled,
   input  wire logic [31:0]        driveSubmodeSetting,
   input  wire logic signed [31:0] accelDemand,
   // controller sources
   output logic [7:0]              positionSource,
   output logic [7:0]              velocitySource,
   output logic [7:0]              commutationSource,
   output logic                    closedLoopActive,
   // acceleration feed-forward
   output logic                    feedForwardEnabled,
   output logic signed [31:0]      accelFeedForward
);
   typedef struct packed {
      logic [NUM_SENSORS-1:0][7:0] shadowMask;  // last written masks
      logic [NUM_SENSORS-1:0][7:0] activeMask;  // masks in force
      logic                        loopClosed;  // loop closure in force
      logic                        opEnPrev;    // operation enabled delayed
      logic                        heldWrite;   // mask written inside operation enabled
      // inertia factor entries
      logic [31:0]                 inCurrent;   // inertia current in mA
      logic [31:0]                 inAccel;     // inertia acceleration
      // object dictionary answer
      logic                        ack;         // answer strobe
      logic                        abort;       // refused access
      logic [31:0]                 rdata;       // read answer
      // controller sources
      logic [7:0]                  posSrc;      // registered sources
      logic [7:0]                  velSrc;
      logic [7:0]                  comSrc;
      // feed-forward divide
      logic                        divStart;    // divider request
      logic                        divPending;  // divider running
      logic                        divNeg;      // demand sign at start
      logic                        ffOn;        // feed-forward enabled
      logic signed [31:0]          ffOut;       // feed-forward value
   } fbs_top_state_type;

   fbs_top_state_type state;        // registered state
   fbs_top_state_type next_state;   // next value

   // feed-forward helpers
   logic [31:0] demandMag;          // magnitude of demand
   logic [63:0] dividend;           // magnitude times current
   logic        divDone;            // divider finished
   logic [31:0] divQuot;            // divider quotient
   // selection and feed-forward enables
   logic        enterOp;            // first cycle of operation enabled
   logic        applyNow;           // shadow copies into force
   logic        factorOn;           // both inertia entries nonzero

   // search for the sources
   fbs_select_if #(.NUM_SENSORS(NUM_SENSORS)) sel ();

   fbs_source_search #(.NUM_SENSORS(NUM_SENSORS)) u_search (
      .sel (sel)
   );

   // the search sees only the masks in force
   assign sel.masks      = state.activeMask;
   assign sel.closedLoop = state.loopClosed;

   // feed-forward quotient current * demand / acceleration
   assign demandMag = accelDemand[31] ? 32'(-accelDemand) : 32'(accelDemand);
   assign dividend  = demandMag * state.inCurrent;

   fbs_ff_divider u_div (
      .clock    (clock),
      .reset_n  (reset_n),
      .start    (state.divStart),
      .dividend (dividend),
      .divisor  (state.inAccel),
      .done     (divDone),
      .quotient (divQuot)
   );

   // first cycle of operation enabled reads the buffer out
   assign enterOp  = operationEnabled && !state.opEnPrev;
   // outside operation enabled masks follow writes, unless one is held for entry
   assign applyNow = enterOp || (!operationEnabled && !state.heldWrite);
   // a zero entry means no feed-forward and no divide by zero
   assign factorOn = (state.inCurrent != 32'h00000000) && (state.inAccel != 32'h00000000);

   // next-state logic
   always_comb begin
      logic [31:0] rd;
      logic        ab;
      logic [31:0] q;
      rd = '0;
      ab = 1'b0;
      q  = '0;
      next_state = state;
      next_state.ack      = 1'b0;
      next_state.abort    = 1'b0;
      next_state.divStart = 1'b0;
      next_state.opEnPrev = operationEnabled;

      // entry reads the buffer out, so nothing is held any more
      if (enterOp) begin
         next_state.heldWrite = 1'b0;
      end

      // object dictionary access, answered the next cycle
      if (odRequest) begin
         // decode the object index
         unique case (odIndex)
            // feedback selection object
            fbs_pkg::SELECT_INDEX: begin
               if (odSubIndex == fbs_pkg::SUB_COUNT) begin
                  // count is read-only
                  rd = {24'h000000, 8'(NUM_SENSORS)};
                  ab = odWrite;
               end else if (odSubIndex != 8'h00 && int'(odSubIndex) <= NUM_SENSORS) begin
                  // selection masks, first one is sensorless
                  rd = {24'h000000, state.shadowMask[odSubIndex-8'h01]};
                  if (odWrite) begin
                     next_state.shadowMask[odSubIndex-8'h01] = odWriteData[7:0];
                     // a write inside operation enabled waits for the next entry
                     if (operationEnabled) begin
                        next_state.heldWrite = 1'b1;
                     end
                  end
               end else begin
                  // subindex beyond the sensors
                  ab = 1'b1;
               end
            end

            // feedback mapping object
            fbs_pkg::MAP_INDEX: begin
               // whole mapping object is read-only
               ab = odWrite;
               // count first, then one index for each of sensors one and two
               if (odSubIndex == fbs_pkg::SUB_COUNT) begin
                  rd = {24'h000000, 8'(NUM_SENSORS)};
               end else if (odSubIndex == fbs_pkg::SUB_FIRST) begin
                  rd = {16'h0000, MAP_FIRST};
               end else if (odSubIndex == fbs_pkg::SUB_SECOND && NUM_SENSORS >= 2) begin
                  rd = {16'h0000, MAP_SECOND};
               end else begin
                  ab = 1'b1;
               end
            end

            // inertia factor object, both entries set by the master
            fbs_pkg::INERTIA_INDEX: begin
               if (odSubIndex == fbs_pkg::SUB_COUNT) begin
                  // count is read-only
                  rd = {24'h000000, fbs_pkg::INERTIA_COUNT};
                  ab = odWrite;
               end else if (odSubIndex == fbs_pkg::SUB_FIRST) begin
                  // current entry in mA
                  rd = state.inCurrent;
                  if (odWrite) begin
                     next_state.inCurrent = odWriteData;
                  end
               end else if (odSubIndex == fbs_pkg::SUB_SECOND) begin
                  // acceleration entry in user units
                  rd = state.inAccel;
                  if (odWrite) begin
                     next_state.inAccel = odWriteData;
                  end
               end else begin
                  ab = 1'b1;
               end
            end

            default: begin
               // index not held by this block
               ab = 1'b1;
            end
         endcase
         // every request is answered, refused or not
         next_state.ack   = 1'b1;
         next_state.abort = ab;
         // writes and refusals answer with zero data
         next_state.rdata = (ab || odWrite) ? 32'h00000000 : rd;
      end

      // bring written values into force
      if (applyNow) begin
         next_state.activeMask = state.shadowMask;
      end
      // loop closure cannot toggle inside operation enabled
      if (!operationEnabled || enterOp) begin
         next_state.loopClosed = driveSubmodeSetting[fbs_pkg::LOOP_BIT];
      end

      // register the search outcome
      next_state.posSrc = sel.posSource;
      next_state.velSrc = sel.velSource;
      next_state.comSrc = sel.comSource;

      // feed-forward: restart the divider after every result
      next_state.ffOn = factorOn;
      // sign taken on the edge at which the divider takes its dividend
      if (state.divStart) begin
         next_state.divNeg = accelDemand[31];
      end
      if (!factorOn) begin
         // a zero entry clears the output at once
         next_state.ffOut = '0;
         // a running divide is let finish before the next start
         next_state.divPending = state.divPending && !divDone;
      end else if (!state.divPending) begin
         // ask for a new quotient
         next_state.divStart   = 1'b1;
         next_state.divPending = 1'b1;
      end else if (divDone) begin
         // result in, clamp to the largest positive value
         next_state.divPending = 1'b0;
         q = divQuot[31] ? 32'h7FFFFFFF : divQuot;
         // braking demand gives a negative feed-forward
         next_state.ffOut = state.divNeg ? -$signed(q) : $signed(q);
      end
   end

   // state register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         // everything else starts at zero
         state <= '0;
         // sensor one is only a fallback, the others start fully selected
         for (int i = 0; i < NUM_SENSORS; i++) begin
            state.shadowMask[i] <= (i == 0) ? fbs_pkg::SEL_FIRST_RST : fbs_pkg::SEL_SECOND_RST;
            state.activeMask[i] <= (i == 0) ? fbs_pkg::SEL_FIRST_RST : fbs_pkg::SEL_SECOND_RST;
         end
         // feed-forward starts disabled
         state.inCurrent <= fbs_pkg::INERTIA_RST;
         state.inAccel   <= fbs_pkg::INERTIA_RST;
         // sources start on the sensorless feedback
         state.posSrc    <= fbs_pkg::SENSORLESS;
         state.velSrc    <= fbs_pkg::SENSORLESS;
         state.comSrc    <= fbs_pkg::SENSORLESS;
      end else begin
         state <= next_state;
      end
   end

   // outputs straight from the state register
   assign odAck              = state.ack;
   assign odAbort            = state.abort;
   assign odReadData         = state.rdata;
   // chosen sources and loop closure
   assign positionSource     = state.posSrc;
   assign velocitySource     = state.velSrc;
   assign commutationSource  = state.comSrc;
   assign closedLoopActive   = state.loopClosed;
   // feed-forward
   assign feedForwardEnabled = state.ffOn;
   assign accelFeedForward   = state.ffOut;
endmodule : fbs_feedback_select

// *** src/fbs_ff_divider.sv ***
`timescale 1ns/1ps
module fbs_ff_divider (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   // request
   input  wire logic        start,
   input  wire logic [63:0] dividend,
   input  wire logic [31:0] divisor,
   // answer
   output logic             done,
   output logic [31:0]      quotient
);
   typedef struct packed {
      logic [32:0] rem;   // partial remainder
      logic [63:0] quo;   // shifting dividend and quotient
      logic [31:0] dsr;   // held divisor
      logic [6:0]  cnt;   // steps left
      logic        done;  // one-cycle completion
   } fbs_div_state_type;

   fbs_div_state_type state;
   fbs_div_state_type next_state;

   // one restoring step per cycle
   always_comb begin
      logic [32:0] trial;
      trial      = '0;
      next_state = state;
      next_state.done = 1'b0;
      if (start && state.cnt == 7'h00) begin
         next_state.rem = '0;
         next_state.quo = dividend;
         next_state.dsr = divisor;
         next_state.cnt = fbs_pkg::DIV_STEPS;
      end else if (state.cnt != 7'h00) begin
         trial = {state.rem[31:0], state.quo[63]};
         next_state.quo = {state.quo[62:0], 1'b0};
         if (trial >= {1'b0, state.dsr}) begin
            trial = trial - {1'b0, state.dsr};
            next_state.quo[0] = 1'b1;
         end
         next_state.rem = trial;
         next_state.cnt = state.cnt - 7'h01;
         next_state.done = (state.cnt == 7'h01);
      end
   end

   // state register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // saturate a quotient that does not fit 32 bits
   assign done     = state.done;
   assign quotient = (state.quo[63:32] != 32'h00000000) ? 32'hFFFFFFFF : state.quo[31:0];
endmodule : fbs_ff_divider

// *** src/fbs_pkg.sv ***
package fbs_pkg;
   // object dictionary indices
   localparam logic [15:0] SELECT_INDEX  = 16'h3203;
   localparam logic [15:0] MAP_INDEX     = 16'h3204;
   localparam logic [15:0] INERTIA_INDEX = 16'h320D;
   // subindices
   localparam logic [7:0]  SUB_COUNT     = 8'h00;
   localparam logic [7:0]  SUB_FIRST     = 8'h01;
   localparam logic [7:0]  SUB_SECOND    = 8'h02;
   // values after reset
   localparam logic [7:0]  SEL_FIRST_RST  = 8'h00;
   localparam logic [7:0]  SEL_SECOND_RST = 8'h07;
   localparam logic [15:0] MAP_FIRST_RST  = 16'h3380;
   localparam logic [15:0] MAP_SECOND_RST = 16'h33A0;
   localparam logic [7:0]  INERTIA_COUNT  = 8'h02;
   localparam logic [31:0] INERTIA_RST    = 32'h00000000;
   // mask bit positions
   localparam int          POS_BIT       = 0;
   localparam int          VEL_BIT       = 1;
   localparam int          COM_BIT       = 2;
   // loop closure bit of the drive submode setting
   localparam int          LOOP_BIT      = 0;
   // sensorless feedback number and first searched sensor
   localparam logic [7:0]  SENSORLESS    = 8'h01;
   localparam int          SEARCH_FIRST  = 2;
   // divider steps for the feed-forward quotient
   localparam logic [6:0]  DIV_STEPS     = 7'h40;
endpackage : fbs_pkg

// *** src/fbs_select_if.sv ***
`timescale 1ns/1ps
interface fbs_select_if #(parameter int NUM_SENSORS = 2);
   logic [NUM_SENSORS-1:0][7:0] masks;       // active selection masks
   logic                        closedLoop;  // loop closure in force
   logic [7:0]                  posSource;   // chosen position sensor
   logic [7:0]                  velSource;   // chosen velocity sensor
   logic [7:0]                  comSource;   // chosen commutation sensor
   modport owner  (output masks, output closedLoop,
                   input posSource, input velSource, input comSource);
   modport search (input masks, input closedLoop,
                   output posSource, output velSource, output comSource);
endinterface : fbs_select_if

// *** src/fbs_source_search.sv ***
`timescale 1ns/1ps
module fbs_source_search #(parameter int NUM_SENSORS = 2) (
   // masks in, sources out
   fbs_select_if.search sel
);
   // descending walk so the lowest matching sensor is the last written
   always_comb begin
      sel.posSource = fbs_pkg::SENSORLESS;
      sel.velSource = fbs_pkg::SENSORLESS;
      sel.comSource = fbs_pkg::SENSORLESS;
      for (int i = NUM_SENSORS; i >= fbs_pkg::SEARCH_FIRST; i--) begin
         if (sel.masks[i-1][fbs_pkg::POS_BIT]) begin
            sel.posSource = 8'(i);
         end
         if (sel.masks[i-1][fbs_pkg::VEL_BIT]) begin
            sel.velSource = 8'(i);
         end
         // commutation bit has no meaning in open loop
         if (sel.closedLoop && sel.masks[i-1][fbs_pkg::COM_BIT]) begin
            sel.comSource = 8'(i);
         end
      end
   end
endmodule : fbs_source_search
